/* File: hdl/mmtimer.sv */
/*
  sixteen-bit multimode timer channel with an apb register slave:
  timer, event counter (with two-phase input), one-shot and pwm modes.
  assumes pins arrive asynchronously and other_overflow comes from logic
  on pclk as a one-cycle pulse.
*/
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module mmtimer
  import mmtimer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins
  input wire logic timer_event_in_pin,
  input wire logic phase_in_pin,
  output logic timer_pulse_out_pin,
  output logic timer_pulse_out_oe,
  // neighbour timers and interrupt
  input wire logic other_overflow,
  output logic wrap_pulse,
  output logic irq
);

  logic [CFG_W-1:0] timer_op_config;
  logic start_flag;
  logic running;
  logic [15:0] reload;
  logic [15:0] cnt;
  logic [15:0] pos;
  logic [7:0] pre;
  logic [PRE_W-1:0] div;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [1:0] a_sync;
  logic [1:0] b_sync;
  logic a_d;
  logic b_d;

  logic [15:0] next_cnt;
  logic [15:0] next_pos;
  logic [7:0] next_pre;
  logic next_running;
  logic wrap;
  logic done;
  logic pwm_level;

  // apb decode
  wire logic [7:0] addr = paddr[7:0];
  wire logic access = psel & penable;
  wire logic first = access & ~pready;
  wire logic wr_done = access & pready & pwrite;
  wire logic rd_done = access & pready & ~pwrite;
  wire logic hit_cfg = (addr == ADDR_CFG);
  wire logic hit_start = (addr == ADDR_START);
  wire logic hit_trig = (addr == ADDR_TRIG);
  wire logic hit_count = (addr == ADDR_COUNT);
  wire logic hit_status = (addr == ADDR_STATUS);
  wire logic hit_mask = (addr == ADDR_MASK);
  wire logic mapped = hit_cfg | hit_start | hit_trig | hit_count |
                      hit_status | hit_mask;
  wire logic [31:0] rd_mux =
    hit_cfg ? {{(32-CFG_W){1'b0}}, timer_op_config} :
    hit_start ? {31'h0, start_flag} :
    hit_count ? {16'h0, cnt} :
    hit_status ? {{(32-STAT_W){1'b0}}, status} :
    hit_mask ? {{(32-STAT_W){1'b0}}, mask} :
    32'h0;

  // configuration fields
  wire op_mode_t mode = op_mode_t'(timer_op_config[OP_SELECT_HIGH:
                                                   OP_SELECT_LOW]);
  wire logic pulse_en = timer_op_config[CFG_PULSE];
  wire logic gate_en = timer_op_config[CFG_GATE_FREE];
  wire logic free_run = timer_op_config[CFG_GATE_FREE];
  wire logic gate_pol = timer_op_config[CFG_GATE_POL];
  wire logic src_other = timer_op_config[CFG_SRC];
  wire logic two_phase = timer_op_config[CFG_TWO_PHASE];
  wire logic quad = timer_op_config[CFG_QUAD];
  wire logic pwm8 = timer_op_config[CFG_PWM8];
  wire logic dir_up = timer_op_config[CFG_UP];
  wire logic [1:0] cksel = timer_op_config[CFG_CKSEL+1:CFG_CKSEL];

  // synchronised pin levels and their edges, second stage only
  wire logic a_s = a_sync[1];
  wire logic b_s = b_sync[1];
  wire logic a_rise = a_s & ~a_d;
  wire logic a_chg = a_s ^ a_d;
  wire logic b_chg = b_s ^ b_d;

  // internal count source
  wire logic src_tick = (cksel == CKSEL_F1) ? 1'b1 :
                        (cksel == CKSEL_F8) ? (div[2:0] == PRE_F8_LAST[2:0]) :
                        (cksel == CKSEL_F32) ? (div == PRE_F32_LAST) :
                        1'b0;
  // gating only applies in timer mode
  wire logic gate_open = ~(gate_en && mode == op_timer) ||
                         (a_s == gate_pol);
  wire logic tick = src_tick & gate_open;

  // event step and direction
  wire logic ev_step = two_phase ? (quad ? (a_chg | b_chg) : a_rise) :
                       (src_other ? other_overflow : a_rise);
  // a leading b counts up; x4 compares old a with new b
  wire logic ev_up = two_phase ? (quad ? ~(a_d ^ b_s) : ~b_s) :
                     dir_up;

  wire logic sw_trig = wr_done & hit_trig & pwdata[0];
  wire logic trig = src_other ? other_overflow : sw_trig;
  wire logic counting = (mode == op_oneshot) ? running : start_flag;
  wire logic cnt_write = wr_done & hit_count;

  wire logic [STAT_W-1:0] stat_set = {done, wrap};
  // clear only what the read returned, so a fresh event survives
  wire logic [STAT_W-1:0] stat_clr =
    (rd_done & hit_status) ? prdata[STAT_W-1:0] : STAT_RST;
  wire logic [STAT_W-1:0] next_status = (status & ~stat_clr) | stat_set;

  always_comb begin
    next_cnt = cnt;
    next_pos = pos;
    next_pre = pre;
    next_running = running;
    wrap = 1'b0;
    done = 1'b0;
    case (mode)
      op_timer: begin
        // n+1 ticks between wraps
        if (start_flag && tick) begin
          if (cnt == 16'h0000) begin
            next_cnt = reload;
            wrap = 1'b1;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
      end
      op_event: begin
        if (start_flag && ev_step) begin
          if (ev_up) begin
            if (cnt == CNT_MAX) begin
              next_cnt = free_run ? 16'h0000 : reload;
              wrap = 1'b1;
            end else begin
              next_cnt = cnt + 16'h0001;
            end
          end else if (cnt == 16'h0000) begin
            next_cnt = free_run ? CNT_MAX : reload;
            wrap = 1'b1;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
      end
      op_oneshot: begin
        // a zero width never starts, so no wrap and no pulse
        if (!running) begin
          if (start_flag && trig && reload != 16'h0000) begin
            next_cnt = reload;
            next_running = 1'b1;
          end
        end else if (!start_flag) begin
          next_running = 1'b0;
        end else if (tick) begin
          next_cnt = cnt - 16'h0001;
          if (cnt == 16'h0001) begin
            next_running = 1'b0;
            wrap = 1'b1;
            done = 1'b1;
          end
        end
      end
      op_pwm: begin
        if (start_flag && tick) begin
          if (pwm8) begin
            if (pre == reload[7:0]) begin
              next_pre = 8'h00;
              if (pos[7:0] == PWM8_LAST) begin
                next_pos = 16'h0000;
                wrap = 1'b1;
              end else begin
                next_pos = pos + 16'h0001;
              end
            end else begin
              next_pre = pre + 8'h01;
            end
          end else if (pos == PWM16_LAST) begin
            next_pos = 16'h0000;
            wrap = 1'b1;
          end else begin
            next_pos = pos + 16'h0001;
          end
        end
      end
      default: begin
        next_cnt = cnt;
      end
    endcase
    pwm_level = start_flag &&
                (pwm8 ? (pos[7:0] < reload[15:8]) : (pos < reload));
  end

  // two-flop synchronisers, edges seen on the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sync <= 2'b00;
      b_sync <= 2'b00;
      a_d <= 1'b0;
      b_d <= 1'b0;
    end else begin
      a_sync <= {a_sync[0], timer_event_in_pin};
      b_sync <= {b_sync[0], phase_in_pin};
      a_d <= a_s;
      b_d <= b_s;
    end
  end

  // apb handshake: one wait state, data latched in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= first;
      pslverr <= first & ~mapped;
      if (first) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_op_config <= CFG_RST;
      start_flag <= 1'b0;
      mask <= MASK_RST;
      reload <= 16'h0000;
    end else begin
      if (wr_done && hit_cfg) begin
        timer_op_config <= pwdata[CFG_W-1:0];
      end
      if (wr_done && hit_start) begin
        start_flag <= pwdata[0];
      end
      if (wr_done && hit_mask) begin
        mask <= pwdata[STAT_W-1:0];
      end
      if (cnt_write) begin
        reload <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      pos <= 16'h0000;
      pre <= 8'h00;
      div <= '0;
      running <= 1'b0;
    end else begin
      div <= div + PRE_W'(1);
      // a config change restarts the pwm phase
      if (wr_done && hit_cfg) begin
        pos <= 16'h0000;
        pre <= 8'h00;
      end else begin
        pos <= next_pos;
        pre <= next_pre;
      end
      running <= next_running;
      if (cnt_write && !counting) begin
        cnt <= pwdata[15:0];
      end else begin
        cnt <= next_cnt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STAT_RST;
      irq <= 1'b0;
      wrap_pulse <= 1'b0;
      timer_pulse_out_pin <= 1'b0;
      timer_pulse_out_oe <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & mask);
      wrap_pulse <= wrap;
      timer_pulse_out_oe <= pulse_en | (mode == op_pwm);
      if (mode == op_pwm) begin
        timer_pulse_out_pin <= pwm_level;
      end else if (pulse_en && wrap) begin
        timer_pulse_out_pin <= ~timer_pulse_out_pin;
      end
    end
  end

endmodule

/* File: hdl/mmtimer_pkg.sv */
/*
  constants for the sixteen-bit multimode timer channel: register byte
  offsets, configuration and status field positions, reset values and the
  internal count source ratios.
  assumes a 32-bit apb slave with word-aligned registers.
*/
package mmtimer_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_START = 8'h04;
  localparam logic [7:0] ADDR_TRIG = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;

  // timer_op_config fields
  localparam int CFG_W = 12;
  localparam int OP_SELECT_LOW = 0;
  localparam int OP_SELECT_HIGH = 1;
  localparam int CFG_PULSE = 2;
  localparam int CFG_GATE_FREE = 3;
  localparam int CFG_GATE_POL = 4;
  localparam int CFG_SRC = 5;
  localparam int CFG_TWO_PHASE = 6;
  localparam int CFG_QUAD = 7;
  localparam int CFG_PWM8 = 8;
  localparam int CFG_UP = 9;
  localparam int CFG_CKSEL = 10;
  localparam logic [CFG_W-1:0] CFG_RST = 12'h000;

  // status and mask fields
  localparam int STAT_W = 2;
  localparam int STAT_WRAP = 0;
  localparam int STAT_DONE = 1;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

  // internal count source select
  localparam logic [1:0] CKSEL_F1 = 2'h0;
  localparam logic [1:0] CKSEL_F8 = 2'h1;
  localparam logic [1:0] CKSEL_F32 = 2'h2;
  localparam int PRE_W = 5;
  localparam logic [PRE_W-1:0] PRE_F8_LAST = 5'h07;
  localparam logic [PRE_W-1:0] PRE_F32_LAST = 5'h1f;

  // counter limits
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] PWM16_LAST = 16'hfffe;
  localparam logic [7:0] PWM8_LAST = 8'hfe;

  typedef enum logic [1:0] {
    op_timer,
    op_event,
    op_oneshot,
    op_pwm
  } op_mode_t;

endpackage

/* File: tb/ext_pulse_model.sv */
/*
  external pulse source: single pulses and two-phase sequences.
  assumes the caller runs on pclk; each level holds four clocks.
*/
`timescale 1ns/1ps
module ext_pulse_model (
  // clock
  input wire logic pclk,
  // driven pins
  output logic pin_a,
  output logic pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  task automatic step(input logic a, input logic b);
    repeat (4) @(posedge pclk);
    pin_a <= a;
    pin_b <= b;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
  endtask
  // a leads b for up, b leads a for down
  task automatic quad(input int n, input logic up);
    repeat (n) begin
      step(up, !up);
      step(1'b1, 1'b1);
      step(!up, up);
      step(1'b0, 1'b0);
    end
  endtask
endmodule

/* File: tb/mmtimer_asserts.sv */
/*
  concurrent checks on the timer channel ports.
  assumes one pclk domain; config and mask are shadowed from apb writes.
*/
`timescale 1ns/1ps
module mmtimer_asserts
  import mmtimer_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and events
  input wire logic timer_event_in_pin,
  input wire logic timer_pulse_out_pin,
  input wire logic timer_pulse_out_oe,
  input wire logic wrap_pulse,
  input wire logic irq
);
  logic wr_ok;
  logic gated;
  logic [CFG_W-1:0] cfg;
  logic [STAT_W-1:0] mask;
  logic [3:0] hold;
  assign wr_ok = psel && penable && pready && pwrite;
  assign gated = cfg[1:0] == 2'h0 && cfg[CFG_GATE_FREE]
    && timer_event_in_pin != cfg[CFG_GATE_POL];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RST;
      mask <= MASK_RST;
      hold <= 4'h0;
    end else begin
      if (wr_ok && paddr[7:0] == ADDR_CFG) cfg <= pwdata[CFG_W-1:0];
      if (wr_ok && paddr[7:0] == ADDR_MASK) mask <= pwdata[STAT_W-1:0];
      // saturates so a long gate never wraps back to zero
      hold <= gated ? hold + {3'h0, hold != 4'hf} : 4'h0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("pready held too long");
  property p_one_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("late pready");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("lone pslverr");
  property p_wr_zero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write read data");
  property p_oe;
    timer_pulse_out_oe == $past(cfg[CFG_PULSE] || cfg[1:0] == 2'h3);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_toggle;
    wrap_pulse && cfg[CFG_PULSE] && cfg[1:0] != 2'h3 && $stable(cfg)
      |-> timer_pulse_out_pin != $past(timer_pulse_out_pin);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");
  property p_gate;
    hold >= 4'h6 |-> !wrap_pulse;
  endproperty
  a_gate: assert property (p_gate) else $error("gated wrap");
  property p_irq_mask;
    irq |-> $past(mask) != 2'h0;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq masked");
endmodule
bind mmtimer mmtimer_asserts #(.ADDR_W(ADDR_W)) mmtimer_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .timer_event_in_pin(timer_event_in_pin),
  .timer_pulse_out_pin(timer_pulse_out_pin),
  .timer_pulse_out_oe(timer_pulse_out_oe),
  .wrap_pulse(wrap_pulse), .irq(irq));

/* File: tb/tb_mmtimer.sv */
/*
  self-checking bench for the timer channel over apb.
  assumes the pulse model drives both input pins.
*/
`timescale 1ns/1ps
module tb_mmtimer;
  import mmtimer_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic other_overflow = 0, pready, pslverr, pin_a, pin_b;
  logic pout, poe, wrap_pulse, irq, err, v;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int errors = 0, checked = 0, g;
  always #5 pclk = ~pclk;
  mmtimer mmtimer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_event_in_pin(pin_a), .phase_in_pin(pin_b),
    .timer_pulse_out_pin(pout), .timer_pulse_out_oe(poe),
    .other_overflow(other_overflow), .wrap_pulse(wrap_pulse), .irq(irq));
  ext_pulse_model ext_pulse_model_inst (.pclk(pclk), .pin_a(pin_a),
    .pin_b(pin_b));
  task automatic finish_test;
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never drives psel twice at once
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  // edges from one wrap pulse to the next
  task automatic wrap_gap;
    g = 0;
    while (wrap_pulse !== 1'b1 && g < 200) begin
      @(posedge pclk);
      g++;
    end
    @(posedge pclk);
    g = 1;
    while (wrap_pulse !== 1'b1 && g < 200) begin
      @(posedge pclk);
      g++;
    end
    if (g >= 200) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic tick_other;
    @(posedge pclk);
    other_overflow <= 1'b1;
    @(posedge pclk);
    other_overflow <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] n);
    wr(ADDR_START, 32'h0);
    wr(ADDR_CFG, c);
    wr(ADDR_COUNT, n);
    wr(ADDR_START, 32'h1);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_MASK, 32'h0, "mask");
    rd(8'h20, 32'h0, "unmapped");
    chk("slverr", 32'h1, 32'(err));
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CFG, 32'(m));
      rd(ADDR_CFG, 32'(m), "mode");
    end
    run(32'h4, 32'h4);
    wrap_gap();
    chk("timer period", 32'h5, 32'(g));
    v = pout;
    wrap_gap();
    chk("out pin", 32'(!v), 32'(pout));
    chk("out enable", 32'h1, 32'(poe));
    run(32'h400, 32'h4);
    wrap_gap();
    chk("divided period", 32'd40, 32'(g));
    wr(ADDR_START, 32'h0);
    wr(ADDR_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    rd(ADDR_STATUS, 32'h1, "status");
    rd(ADDR_STATUS, 32'h0, "status clear");
    repeat (3) @(posedge pclk);
    chk("irq clear", 32'h0, 32'(irq));
    run(32'h18, 32'h9);
    repeat (20) @(posedge pclk);
    rd(ADDR_COUNT, 32'h9, "gated");
    wr(ADDR_COUNT, 32'h3);
    rd(ADDR_COUNT, 32'h9, "reload only");
    ext_pulse_model_inst.step(1'b1, 1'b0);
    repeat (12) @(posedge pclk);
    apb(ADDR_COUNT, 1'b0, 32'h0);
    chk("gate open", 32'h1, 32'(q[15:0] < 16'h4));
    ext_pulse_model_inst.step(1'b0, 1'b0);
    run(32'h1, 32'd10);
    ext_pulse_model_inst.pulses(3);
    repeat (6) @(posedge pclk);
    rd(ADDR_COUNT, 32'd7, "event down");
    run(32'h20d, 32'hfffe);
    ext_pulse_model_inst.pulses(3);
    repeat (6) @(posedge pclk);
    rd(ADDR_COUNT, 32'h1, "free run");
    run(32'h21, 32'h5);
    tick_other();
    tick_other();
    repeat (3) @(posedge pclk);
    rd(ADDR_COUNT, 32'h3, "other overflow");
    run(32'h41, 32'd100);
    ext_pulse_model_inst.quad(2, 1'b1);
    ext_pulse_model_inst.quad(1, 1'b0);
    repeat (6) @(posedge pclk);
    rd(ADDR_COUNT, 32'd101, "two phase");
    run(32'hc1, 32'd100);
    ext_pulse_model_inst.quad(1, 1'b1);
    repeat (6) @(posedge pclk);
    rd(ADDR_COUNT, 32'd104, "times four");
    run(32'h103, 32'h0300);
    repeat (4) @(posedge pclk);
    g = 0;
    for (int i = 0; i < 255; i++) begin
      @(posedge pclk);
      if (pout === 1'b1) g++;
    end
    chk("pwm high", 32'h3, 32'(g));
    for (int s = 0; s < 2; s++) begin
      run(32'h6 | 32'(s << 5), 32'h5);
      if (s == 1) tick_other();
      else wr(ADDR_TRIG, 32'h1);
      repeat (20) @(posedge pclk);
      rd(ADDR_COUNT, 32'h0, "one shot end");
      apb(ADDR_STATUS, 1'b0, 32'h0);
      chk("one shot done", 32'h1, 32'(q[STAT_DONE]));
    end
    finish_test();
  end
endmodule
